// ==== rtl/acc_cal_ctrl.sv ====
/*
  adc calibration control register and input channel decode.
  assumes the core presents special function register accesses as one-cycle
  read and write strobes with an 8-bit address, and returns read data in the
  cycle after the read strobe.
*/
`timescale 1ns/1ps
`include "acc_consts.svh"
module acc_cal_ctrl (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [3:0] channel_code,
  input wire logic conv_start,
  input wire logic adc_done,
  output logic adc_req,
  output logic adc_gain,
  output acc_pkg::acc_input_e input_sel,
  output logic dma_stop,
  output logic channel_reserved
);
  import acc_pkg::*;
  acc_cal_if cal ();
  acc_ctrl_s c_reg, c_next;
  logic [7:0] reg_view;
  logic hit_wr;
  logic hit_rd;

  function automatic logic [6:0] avg_reads(input logic [1:0] f);
    unique case (f)
      2'b00: avg_reads = `ACC_AVG_00;
      2'b01: avg_reads = `ACC_AVG_01;
      2'b10: avg_reads = `ACC_AVG_10;
      2'b11: avg_reads = `ACC_AVG_11;
    endcase
  endfunction

  function automatic logic cal_addr(input logic [7:0] a);
    cal_addr = (a == `ACC_CAL_ADDR);
  endfunction

  assign hit_wr = sfr_wr && cal_addr(sfr_addr);
  assign hit_rd = sfr_rd && cal_addr(sfr_addr);

  always_comb
  begin
    c_next = c_reg;
    // start clears at completion, with busy
    if (cal.cal_done)
      c_next.start = 1'b0;
    if (hit_wr)
    begin
      c_next.avg = sfr_wdata[`ACC_BIT_AVG_HI:`ACC_BIT_AVG_LO];
      c_next.cal_en = sfr_wdata[`ACC_BIT_CAL_EN];
      c_next.cal_type = sfr_wdata[`ACC_BIT_TYPE];
      // a one starts a cycle; a zero cannot abort a running one
      if (sfr_wdata[`ACC_BIT_START] && !cal.cal_busy)
        c_next.start = 1'b1;
    end
    // answer a read in the next cycle
    c_next.rdata = hit_rd ? reg_view : 8'h00;
  end

  // launch the cycle after the write so the sequencer sees settled fields
  assign cal.launch = c_reg.start && !cal.cal_busy;
  assign cal.gain_sel = c_reg.cal_type;
  assign cal.reads = avg_reads(c_reg.avg);
  assign cal.channel = channel_code;

  // busy is read-only; reserved bits read zero
  always_comb
  begin
    reg_view = 8'h00;
    reg_view[`ACC_BIT_BUSY] = cal.cal_busy || cal.conv_busy || c_reg.start;
    reg_view[`ACC_BIT_AVG_HI:`ACC_BIT_AVG_LO] = c_reg.avg;
    reg_view[`ACC_BIT_CAL_EN] = c_reg.cal_en;
    reg_view[`ACC_BIT_TYPE] = c_reg.cal_type;
    reg_view[`ACC_BIT_START] = c_reg.start;
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      c_reg <= '{avg: 2'b00, cal_en: 1'b0, cal_type: 1'b0, start: 1'b0, rdata: 8'h00};
    else
      c_reg <= c_next;
  end
  assign sfr_rdata = c_reg.rdata;

  always_comb
  begin
    input_sel = ACC_IN_PIN;
    channel_reserved = 1'b0;
    unique case (channel_code)
      `ACC_CH_TEMP: input_sel = ACC_IN_TEMP;
      `ACC_CH_ANALOG_GROUND_INPUT: input_sel = ACC_IN_ANALOG_GROUND_INPUT;
      `ACC_CH_VREF: input_sel = ACC_IN_VREF;
      4'hD, 4'hE: channel_reserved = 1'b1;
      default: input_sel = ACC_IN_PIN;
    endcase
  end
  // the list end marker is only flagged, software places it
  assign dma_stop = (channel_code == `ACC_CH_DMA_STOP);

  acc_cal_seq u_seq (
    .clock(clock),
    .nrst(nrst),
    .bus(cal),
    .conv_start(conv_start),
    .adc_done(adc_done),
    .adc_req(adc_req),
    .adc_gain(adc_gain)
  );

  // cycles spent acquiring, helper for the span check
  logic [8:0] acq_seen;
  always_ff @(posedge clock)
  begin
    if (!nrst || !cal.cal_busy)
      acq_seen <= 9'h000;
    else if (!adc_req && acq_seen != 9'h1FF)
      acq_seen <= acq_seen + 9'h001;
  end

  a_start_busy_fall: assert property (@(posedge clock) disable iff (!nrst)
    $fell(c_reg.start) |-> !cal.cal_busy && !reg_view[`ACC_BIT_BUSY] || cal.conv_busy)
    else $error("start bit fell apart from busy");
  a_fall_together: assert property (@(posedge clock) disable iff (!nrst)
    $fell(c_reg.start) |-> $fell(cal.cal_busy))
    else $error("start bit and busy fell on different edges");
  a_start_auto_clr: assert property (@(posedge clock) disable iff (!nrst)
    cal.cal_done && !hit_wr |=> !c_reg.start) else $error("start bit not cleared at completion");
  a_start_launch: assert property (@(posedge clock) disable iff (!nrst)
    hit_wr && sfr_wdata[`ACC_BIT_START] && !cal.cal_busy |=> ##1 cal.cal_busy)
    else $error("calibration did not begin");
  a_no_abort: assert property (@(posedge clock) disable iff (!nrst)
    hit_wr && cal.cal_busy && !cal.cal_done |=> c_reg.start && cal.cal_busy)
    else $error("running calibration stopped by a write");
  // no second launch from a busy write
  a_no_relaunch: assert property (@(posedge clock) disable iff (!nrst)
    hit_wr && cal.cal_busy |=> !cal.launch)
    else $error("calibration relaunched while busy");
  a_busy_during_cal: assert property (@(posedge clock) disable iff (!nrst)
    cal.cal_busy |-> reg_view[`ACC_BIT_BUSY]) else $error("busy low during calibration");
  a_busy_readonly: assert property (@(posedge clock) disable iff (!nrst)
    hit_wr && sfr_wdata[`ACC_BIT_BUSY] && !sfr_wdata[`ACC_BIT_START] && !reg_view[`ACC_BIT_BUSY] && !conv_start
    |=> !reg_view[`ACC_BIT_BUSY])
    else $error("busy bit taken from a write");
  a_conv_busy: assert property (@(posedge clock) disable iff (!nrst)
    conv_start && !cal.cal_busy |=> reg_view[`ACC_BIT_BUSY])
    else $error("busy low during conversion");
  // busy drops when the conversion ends
  a_conv_idle: assert property (@(posedge clock) disable iff (!nrst)
    adc_done && !cal.cal_busy && !c_reg.start && !conv_start && !hit_wr |=> !reg_view[`ACC_BIT_BUSY])
    else $error("busy stuck after conversion");
  a_avg_single: assert property (@(posedge clock) disable iff (!nrst)
    cal.launch && c_reg.avg == 2'b01 |-> cal.reads == 7'h01) else $error("wrong average count");
  a_avg_fifteen: assert property (@(posedge clock) disable iff (!nrst)
    cal.launch && c_reg.avg == 2'b00 |-> cal.reads == 7'h0F)
    else $error("wrong average count for field 00");
  a_avg_thirty_one: assert property (@(posedge clock) disable iff (!nrst)
    cal.launch && c_reg.avg == 2'b10 |-> cal.reads == 7'h1F)
    else $error("wrong average count for field 10");
  a_avg_sixty_three: assert property (@(posedge clock) disable iff (!nrst)
    cal.launch && c_reg.avg == 2'b11 |-> cal.reads == 7'h3F)
    else $error("wrong average count for field 11");
  a_write_fields: assert property (@(posedge clock) disable iff (!nrst)
    hit_wr |=> c_reg.avg == $past(sfr_wdata[`ACC_BIT_AVG_HI:`ACC_BIT_AVG_LO])
    && c_reg.cal_type == $past(sfr_wdata[`ACC_BIT_TYPE]))
    else $error("written fields not stored");
  a_reset_value: assert property (@(posedge clock) disable iff (!nrst)
    $rose(nrst) |-> reg_view == `ACC_CAL_RESET)
    else $error("register not at power-on value");
  a_read_fields: assert property (@(posedge clock) disable iff (!nrst)
    sfr_rd && sfr_addr == `ACC_CAL_ADDR |=> sfr_rdata[5:0] == $past(reg_view[5:0]) && !sfr_rdata[6] && !sfr_rdata[3])
    else $error("register read mismatch");
  // read data only after a read
  a_rdata_quiet: assert property (@(posedge clock) disable iff (!nrst)
    !hit_rd |=> sfr_rdata == 8'h00)
    else $error("read data present without a read");
  // writes elsewhere leave the fields alone
  a_other_addr: assert property (@(posedge clock) disable iff (!nrst)
    sfr_wr && !cal_addr(sfr_addr) |=> $stable(c_reg.avg) && $stable(c_reg.cal_en) && $stable(c_reg.cal_type))
    else $error("write to another address changed the register");
  a_type_follow: assert property (@(posedge clock) disable iff (!nrst)
    cal.launch |=> adc_gain == $past(c_reg.cal_type)) else $error("calibration type not applied");
  // temperature input acquired for the full span
  a_temp_acq_span: assert property (@(posedge clock) disable iff (!nrst)
    $rose(adc_req) && channel_code == `ACC_CH_TEMP |-> acq_seen >= 9'(`ACC_TEMP_ACQ_CYC))
    else $error("temperature acquisition too short");
  a_temp_decode: assert property (@(posedge clock) disable iff (!nrst)
    channel_code == `ACC_CH_TEMP |-> input_sel == ACC_IN_TEMP && !channel_reserved)
    else $error("temperature channel misdecoded");
  a_vref_decode: assert property (@(posedge clock) disable iff (!nrst)
    channel_code == `ACC_CH_VREF |-> input_sel == ACC_IN_VREF && !channel_reserved)
    else $error("reference channel misdecoded");
  a_analog_ground_input_decode: assert property (@(posedge clock) disable iff (!nrst)
    channel_code == `ACC_CH_ANALOG_GROUND_INPUT |-> input_sel == ACC_IN_ANALOG_GROUND_INPUT && !channel_reserved)
    else $error("ground channel misdecoded");
  a_rsvd_decode: assert property (@(posedge clock) disable iff (!nrst)
    (channel_code == 4'hD || channel_code == 4'hE) |-> channel_reserved && input_sel == ACC_IN_PIN && !dma_stop)
    else $error("reserved channel not flagged");
  a_stop_decode: assert property (@(posedge clock) disable iff (!nrst)
    channel_code == `ACC_CH_DMA_STOP |-> dma_stop && !channel_reserved)
    else $error("list end marker not flagged");
endmodule

// ==== rtl/acc_cal_if.sv ====
/*
  carrier between the register front end and the calibration sequencer.
  assumes one clock domain.
*/
`timescale 1ns/1ps
interface acc_cal_if;
  logic launch;
  logic gain_sel;
  logic [6:0] reads;
  logic [3:0] channel;
  logic cal_busy;
  logic cal_done;
  logic conv_busy;
  modport ctrl (output launch, output gain_sel, output reads, output channel,
                input cal_busy, input cal_done, input conv_busy);
  modport seq (input launch, input gain_sel, input reads, input channel,
               output cal_busy, output cal_done, output conv_busy);
endinterface

// ==== rtl/acc_cal_seq.sv ====
/*
  calibration sequencer: acquires then collects the chosen number of readings.
  assumes the converter answers each read request with a one-cycle done pulse.
*/
`timescale 1ns/1ps
`include "acc_consts.svh"
module acc_cal_seq (
  input wire logic clock,
  input wire logic nrst,
  acc_cal_if.seq bus,
  input wire logic conv_start,
  input wire logic adc_done,
  output logic adc_req,
  output logic adc_gain
);
  import acc_pkg::*;
  localparam logic [8:0] ACQ_CYC = 9'(`ACC_TEMP_ACQ_CYC);
  acc_seq_s s_reg, s_next;
  always_comb
  begin
    s_next = s_reg;
    unique case (s_reg.state)
      ACC_IDLE:
      begin
        if (bus.launch)
        begin
          s_next.state = ACC_ACQ;
          s_next.reads_left = bus.reads;
          s_next.gain_sel = bus.gain_sel;
          s_next.acq_left = ACQ_CYC;
        end
      end
      ACC_ACQ:
      begin
        if (bus.channel != `ACC_CH_TEMP || s_reg.acq_left <= 9'h001)
          s_next.state = ACC_READ;
        else
          s_next.acq_left = s_reg.acq_left - 9'h001;
      end
      ACC_READ:
      begin
        if (adc_done)
        begin
          s_next.reads_left = s_reg.reads_left - 7'h01;
          if (s_reg.reads_left == 7'h01)
            s_next.state = ACC_DONE;
        end
      end
      ACC_DONE:
        s_next.state = ACC_IDLE;
    endcase
    if (conv_start && s_reg.state == ACC_IDLE)
      s_next.conv_busy = 1'b1;
    else if (adc_done && s_reg.state == ACC_IDLE)
      s_next.conv_busy = 1'b0;
  end
  always_ff @(posedge clock)
  begin
    if (!nrst)
      s_reg <= '{state: ACC_IDLE, reads_left: 7'h00, acq_left: 9'h000, gain_sel: 1'b0, conv_busy: 1'b0};
    else
      s_reg <= s_next;
  end
  assign bus.cal_busy = (s_reg.state != ACC_IDLE);
  assign bus.cal_done = (s_reg.state == ACC_DONE);
  assign bus.conv_busy = s_reg.conv_busy;
  assign adc_req = (s_reg.state == ACC_READ);
  // type drives the converter gain choice
  assign adc_gain = s_reg.gain_sel;
  a_temp_acq_len: assert property (@(posedge clock) disable iff (!nrst)
    (s_reg.state == ACC_IDLE && bus.launch && bus.channel == `ACC_CH_TEMP)
    |=> (s_reg.state == ACC_ACQ) [*8]) else $error("temperature acquisition cut short");
endmodule

// ==== rtl/acc_consts.svh ====
/*
  constants of the adc calibration control block: register address, field
  positions, reset value, channel codes and timing counts.
  assumes a 250 MHz core clock and the special function register bus of the core.
*/
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH
`define ACC_CAL_ADDR 8'hF5
`define ACC_CAL_RESET 8'h00
`define ACC_BIT_BUSY 7
`define ACC_BIT_RSVD6 6
`define ACC_BIT_AVG_HI 5
`define ACC_BIT_AVG_LO 4
`define ACC_BIT_RSVD3 3
`define ACC_BIT_CAL_EN 2
`define ACC_BIT_TYPE 1
`define ACC_BIT_START 0
`define ACC_AVG_00 7'h0F
`define ACC_AVG_01 7'h01
`define ACC_AVG_10 7'h1F
`define ACC_AVG_11 7'h3F
`define ACC_CH_TEMP 4'h8
`define ACC_CH_ANALOG_GROUND_INPUT 4'hB
`define ACC_CH_VREF 4'hC
`define ACC_CH_DMA_STOP 4'hF
`define ACC_CLK_MHZ 250
`define ACC_TEMP_ACQ_NS 1000
`define ACC_TEMP_ACQ_CYC ((`ACC_TEMP_ACQ_NS * `ACC_CLK_MHZ + 999) / 1000)
`endif

// ==== rtl/acc_pkg.sv ====
/*
  types of the adc calibration control block.
  assumes acc_consts.svh is included by its users.
*/
package acc_pkg;
  typedef enum logic [1:0] {ACC_IN_PIN, ACC_IN_TEMP, ACC_IN_ANALOG_GROUND_INPUT, ACC_IN_VREF} acc_input_e;
  typedef enum logic [1:0] {ACC_IDLE, ACC_ACQ, ACC_READ, ACC_DONE} acc_state_e;
  typedef struct packed {
    acc_state_e state;
    logic [6:0] reads_left;
    logic [8:0] acq_left;
    logic gain_sel;
    logic conv_busy;
  } acc_seq_s;
  typedef struct packed {
    logic [1:0] avg;
    logic cal_en;
    logic cal_type;
    logic start;
    logic [7:0] rdata;
  } acc_ctrl_s;
endpackage

// ==== verification/acc_cal_ctrl_tb.sv ====
/*
  self-checking bench of the adc calibration control block.
  assumes acc_pkg, acc_cal_if, acc_cal_seq and acc_cal_ctrl compiled first.
*/
`timescale 1ns/1ps
module acc_cal_ctrl_tb;
  import acc_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] sfr_addr = 8'hF5;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic [3:0] channel_code = 4'h0;
  logic conv_start = 1'b0;
  logic adc_done = 1'b0;
  logic adc_req;
  logic adc_gain;
  acc_input_e input_sel;
  logic dma_stop;
  logic channel_reserved;
  int n_fail = 0;
  int n_compared = 0;
  logic [7:0] rv;
  int avg_tab [4] = '{15, 1, 31, 63};

  acc_cal_ctrl dut_u (.clock(clock), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .channel_code(channel_code),
    .conv_start(conv_start), .adc_done(adc_done), .adc_req(adc_req), .adc_gain(adc_gain),
    .input_sel(input_sel), .dma_stop(dma_stop), .channel_reserved(channel_reserved));

  initial
  begin
    forever #2 clock = ~clock;
  end

  task automatic stop_test();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // inputs always move 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
  endtask

  // read data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    cyc(1);
    sfr_addr = a;
    sfr_rd = 1'b1;
    cyc(1);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask

  task automatic pulse_done();
    adc_done = 1'b1;
    cyc(1);
    adc_done = 1'b0;
    cyc(1);
  endtask

  task automatic cal(input logic [1:0] avg, input logic typ, input int lo);
    int k;
    k = 0;
    wr(8'hF5, {2'b00, avg, 2'b01, typ, 1'b1});
    rd(8'hF5, rv);
    chk("running", {2'b10, avg, 2'b01, typ, 1'b1}, rv);
    while (adc_req !== 1'b1 && k < 400)
    begin
      cyc(1);
      k++;
    end
    chk("acq wait", 8'h01, {7'h00, k + 1 >= lo});
    chk("gain", {7'h00, typ}, {7'h00, adc_gain});
    repeat (avg_tab[avg])
    begin
      chk("req", 8'h01, {7'h00, adc_req});
      pulse_done();
    end
    chk("req end", 8'h00, {7'h00, adc_req});
    rd(8'hF5, rv);
    chk("finished", {2'b00, avg, 2'b01, typ, 1'b0}, rv);
  endtask

  initial
  begin
    cyc(10);
    nrst = 1'b1;
    rd(8'hF5, rv);
    chk("reset value", 8'h00, rv);
    conv_start = 1'b1;
    cyc(1);
    conv_start = 1'b0;
    rd(8'hF5, rv);
    chk("conv busy", 8'h80, rv);
    pulse_done();
    rd(8'hF5, rv);
    chk("conv idle", 8'h00, rv);
    wr(8'hF5, 8'hB6);
    rd(8'hF5, rv);
    chk("fields", 8'h36, rv);
    wr(8'hF4, 8'h11);
    rd(8'hF4, rv);
    chk("unmapped", 8'h00, rv);
    rd(8'hF5, rv);
    chk("kept", 8'h36, rv);
    for (int a = 0; a < 4; a++)
      cal(a[1:0], a[0], 1);
    wr(8'hF5, 8'h15);
    wr(8'hF5, 8'h36);
    rd(8'hF5, rv);
    chk("no abort", 8'hB7, rv);
    chk("kept gain", 8'h02, {6'h00, adc_req, adc_gain});
    pulse_done();
    chk("one read", 8'h00, {7'h00, adc_req});
    rd(8'hF5, rv);
    chk("after abort try", 8'h36, rv);
    wr(8'hF5, 8'h27);
    cyc(3);
    nrst = 1'b0;
    cyc(2);
    nrst = 1'b1;
    rd(8'hF5, rv);
    chk("reset again", 8'h00, rv);
    chk("reset outputs", 8'h00, {6'h00, adc_req, adc_gain});
    channel_code = 4'h8;
    cal(2'b01, 1'b1, 250);
    for (int c = 0; c < 16; c++)
    begin
      channel_code = c[3:0];
      cyc(1);
      if (c < 9 || c == 11 || c == 12)
        chk("input_sel", {6'h00, (c == 8) ? ACC_IN_TEMP : (c == 11) ? ACC_IN_ANALOG_GROUND_INPUT :
          (c == 12) ? ACC_IN_VREF : ACC_IN_PIN}, {6'h00, input_sel});
      chk("flags", {6'h00, c == 15, c == 13 || c == 14}, {6'h00, dma_stop, channel_reserved});
    end
    stop_test();
  end

  // whole run is near 565 cycles
  initial
  begin
    repeat (20000) @(posedge clock);
    n_fail++;
    $display("unexpected watchdog: expected end, seen hang");
    stop_test();
  end
endmodule
